// [hw/lamp_cell.sv]
`timescale 1ns/100ps
module lamp_cell (
   // Clock and resets
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic retain_clr_i,
   // Signal set and configuration
   input wire logic [lamp_pkg::SIG_W-1:0] sig_i,
   input wire logic [lamp_pkg::SLOTS*lamp_pkg::SEL_W-1:0] slot_sel_i,
   input wire logic [lamp_pkg::SLOTS-1:0] slot_neg_i,
   input wire logic [1:0] mode_i,
   input wire logic [lamp_pkg::COL_W-1:0] on_colour_select_i,
   input wire logic [lamp_pkg::COL_W-1:0] off_colour_select_i,
   input wire logic [lamp_pkg::SEL_W-1:0] clr_sel_i,
   // Acknowledge requests and flash phase
   input wire logic group_ack_i,
   input wire logic alarm_ack_i,
   input wire logic flash_i,
   // Lamp drive and state
   output logic red_o,
   output logic green_o,
   output logic active_o,
   output logic latched_o
);
   import lamp_pkg::*;

   logic [SLOTS-1:0] slot_used;  // Slot has a valid select
   logic [SLOTS-1:0] slot_val;   // Slot contribution
   logic trig;                   // Combined trigger
   logic own_clr;                // Per-lamp clear source
   logic ack;                    // Any acknowledge this cycle
   logic release_ok;             // Latch may drop
   logic latch_r;
   logic [COL_W-1:0] col;

   ////////////////////////////////////////////////////////////////////////
   // Trigger slots
   for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      logic [SEL_W-1:0] sel;
      assign sel = slot_sel_i[s*SEL_W +: SEL_W];
      // Selects past the signal set count as unassigned
      assign slot_used[s] = (sel != '0) && (sel <= SEL_W'(SIG_W));
      // Unassigned gives 0, negate ignored
      assign slot_val[s] = slot_used[s] &
         (sig_i[5'(sel - 6'h01)] ^ slot_neg_i[s]);
   end

   // Up to five slots ORed together
   assign trig = |slot_val;

   // Own clear source, only meaningful when latching
   assign own_clr = (clr_sel_i != '0) && (clr_sel_i <= SEL_W'(SIG_W)) &&
      (mode_i != LATCH_OFF) && sig_i[5'(clr_sel_i - 6'h01)];

   // Alarm acknowledge only for the alarm-cleared mode
   assign ack = group_ack_i | own_clr |
      (alarm_ack_i & (mode_i == CLEAR_ON_ALARM_LATCH_MODE));

   // Release needs all triggers gone; an early ack is dropped
   assign release_ok = ~trig & (ack | (mode_i == LATCH_OFF) |
      ~(|slot_used));

   ////////////////////////////////////////////////////////////////////////
   // Latch; untouched by system reset so restarts keep it
   always_ff @(posedge ref_clk_i) begin
      if (retain_clr_i) begin
         latch_r <= 1'b0;
      end else if (sys_rst_i) begin
         // Frozen while the rest of the block restarts
         latch_r <= latch_r;
      end else if (trig && (mode_i != LATCH_OFF)) begin
         latch_r <= 1'b1;
      end else if (release_ok) begin
         latch_r <= 1'b0;
      end
   end

   // Unlatched lamps follow the triggers directly
   assign active_o = trig | latch_r;
   assign latched_o = latch_r;

   // Colour by state
   assign col = active_o ? on_colour_select_i : off_colour_select_i;

   ////////////////////////////////////////////////////////////////////////
   // Registered lamp drive
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         red_o <= 1'b0;
         green_o <= 1'b0;
      end else begin
         red_o <= (col == COL_RED) | ((col == COL_RED_FLASH) & flash_i);
         green_o <= (col == COL_GREEN) |
            ((col == COL_GREEN_FLASH) & flash_i);
      end
   end

endmodule

// [hw/lamp_panel.sv]
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - Each lamp ORs up to five triggers
// - Per-slot negate inverts that slot's trigger
// - Unassigned slot gives 0, negate ignored
// - Latched lamp holds state until acknowledged
// - Unlatched lamp follows combined trigger state
// - Own clear releases latch once triggers inactive
// - Active lamp shows selected on colour
// - Inactive lamp shows selected off colour
// - Release needs idle triggers plus clearing cause
// - Latched state survives system reset, not power-on clear
// - Global clear source acknowledges all lamps
// - Global and remote clear need permit
// - Protection alarm clears alarm-mode lamps
// - Panel clear key acknowledges latched lamps
// - Health lamp flashes green, then steady
module lamp_panel #(
   parameter int unsigned FLASH_CYC = lamp_pkg::FLASH_HALF_CYC
) (
   // Clock and resets
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic pwr_on_clr_i,
   // Avalon-MM slave
   input wire logic [lamp_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Internal protection signals
   input wire logic [lamp_pkg::SIG_W-1:0] sig_i,
   input wire logic prot_alarm_i,
   input wire logic boot_done_i,
   input wire logic prot_active_i,
   // Front panel key, asynchronous pin
   input wire logic clear_key_i,
   // Lamp drive
   output logic [lamp_pkg::NUM_LAMPS-1:0] lamp_red_o,
   output logic [lamp_pkg::NUM_LAMPS-1:0] lamp_green_o,
   output logic health_green_o
);
   import lamp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Register map
   //   CTRL   permit, global source, remote ack
   //   STATUS active and latched lamps, boot
   //   TRIG   five slot selects per lamp
   //   CFG    negate, mode, colours, own clear
   // Lamp words repeat every 16 bytes.
   // Select zero, or past the signal set,
   // leaves a slot unassigned.
   // Lamp settings and latches ride through a
   // system reset; only power-on clear
   // wipes them, so lamps come back as
   // they were after a restart.

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [31:0] ctrl_r;                  // Permit, global source
   logic [31:0] trig_r [NUM_LAMPS];      // Slot selects per lamp
   logic [31:0] cfg_r [NUM_LAMPS];       // Lamp options
   // Bus side
   logic rack_r;                         // Remote ack pulse
   logic ack_r;                          // Bus answer phase
   logic [31:0] rdata_r;                 // Read data holding
   logic req;                            // Request present
   logic wr_go;                          // Write takes effect
   logic ctrl_hit;
   logic stat_hit;
   logic lamp_hit;
   logic [7:0] lamp_ofs;                 // Offset inside lamp area
   logic [2:0] lamp_idx;                 // Selected lamp
   logic [31:0] rd_nxt;
   // Acknowledge sources
   logic [2:0] key_sync_r;               // Key synchroniser and edge
   logic key_press;
   logic [5:0] gsrc_sel;
   logic gsrc_val;                       // Global clear source level
   logic group_ack;
   // Lamp side
   logic [24:0] flash_cnt_r;
   logic flash_r;                        // Common flash phase
   logic [NUM_LAMPS-1:0] active;
   logic [NUM_LAMPS-1:0] latched;

   ////////////////////////////////////////////////////////////////////////
   // Byte lane merge for writes
   // Lanes with byteenable low keep their
   // old byte, so partial writes are safe
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   assign req = avs_read_i | avs_write_i;
   assign wr_go = avs_write_i & ack_r;
   assign ctrl_hit = (avs_address_i == CTRL_OFS);
   assign stat_hit = (avs_address_i == STAT_OFS);
   assign lamp_ofs = avs_address_i - LAMP_BASE;
   assign lamp_idx = lamp_ofs[6:4];
   // Lamp area, only the two words of each lamp are mapped
   assign lamp_hit = (avs_address_i >= LAMP_BASE) &&
      (lamp_ofs < 8'(NUM_LAMPS * 16)) &&
      ((lamp_ofs[3:0] == TRIG_WORD) || (lamp_ofs[3:0] == CFG_WORD));

   // Unmapped words give no hit: reads return
   // zero, writes are dropped, same timing
   // One wait cycle on every access keeps read data registered
   assign avs_waitrequest_o = req & ~ack_r;
   assign avs_readdata_o = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // Answer phase: high for one cycle after a request is seen
   // Reset drops it; a pending request restarts
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ack_r <= 1'b0;
      end else begin
         // One cycle per request; the held request
         // then sees waitrequest low and completes
         ack_r <= req & ~ack_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses read zero
   // Status is live as of the first read edge
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (ctrl_hit) begin
         // Remote ack bit is a strobe and reads back zero
         rd_nxt = ctrl_r;
         rd_nxt[CTRL_RACK_BIT] = 1'b0;
      end else if (stat_hit) begin
         rd_nxt[NUM_LAMPS-1:0] = active;
         rd_nxt[STAT_LATCH_LSB +: NUM_LAMPS] = latched;
         rd_nxt[STAT_BOOT_BIT] = boot_done_i;
      end else if (lamp_hit) begin
         if (lamp_ofs[3:0] == TRIG_WORD) begin
            rd_nxt = trig_r[lamp_idx];
         end else begin
            rd_nxt = cfg_r[lamp_idx];
         end
      end
   end

   // Read data captured while waitrequest is high
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read_i && !ack_r) begin
         // Taken at the first edge of the read, so
         // data stand while waitrequest is low
         rdata_r <= rd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register; strobe bit never stored
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_go && ctrl_hit) begin
         // Only permit and source are kept; the
         // rest reads zero, as software expects
         ctrl_r <= be_merge(ctrl_r, avs_writedata_i, avs_byteenable_i) &
            32'h0000_007F;
      end
   end

   // Remote all-lamp acknowledge, one cycle pulse
   // Acts the cycle after the write edge, with
   // the permit of that write already in force
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rack_r <= 1'b0;
      end else begin
         rack_r <= wr_go & ctrl_hit & avs_byteenable_i[1] &
            avs_writedata_i[CTRL_RACK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lamp configuration words, cleared at power-on only; a
   // system reset must not touch them, or latched lamps would
   // lose mode and colours and drop right after it
   always_ff @(posedge ref_clk_i) begin
      if (pwr_on_clr_i) begin
         for (int i = 0; i < NUM_LAMPS; i++) begin
            trig_r[i] <= TRIG_RST;
            cfg_r[i] <= CFG_RST;
         end
      end else if (wr_go && lamp_hit) begin
         if (lamp_ofs[3:0] == TRIG_WORD) begin
            trig_r[lamp_idx] <= be_merge(trig_r[lamp_idx],
               avs_writedata_i, avs_byteenable_i);
         end else begin
            cfg_r[lamp_idx] <= be_merge(cfg_r[lamp_idx],
               avs_writedata_i, avs_byteenable_i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clear key: two flops, then a third for the press edge
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         key_sync_r <= 3'h0;
      end else begin
         key_sync_r <= {key_sync_r[1:0], clear_key_i};
      end
   end

   // The second and third flops feed logic; the first may
   // be metastable, the third keeps the last level
   // A press is one acknowledge; holding the key adds nothing
   assign key_press = key_sync_r[1] & ~key_sync_r[2];

   ////////////////////////////////////////////////////////////////////////
   // Global clear source from the signal set
   assign gsrc_sel = ctrl_r[CTRL_GSRC_LSB +: SEL_W];
   assign gsrc_val = (gsrc_sel != '0) && (gsrc_sel <= SEL_W'(SIG_W)) &&
      sig_i[5'(gsrc_sel - 6'h01)];

   // Global source is a level: held high it
   // clears lamps once their triggers go idle
   // Remote paths gated by the permit; panel key is always honoured
   assign group_ack = key_press |
      (ctrl_r[CTRL_PERMIT_BIT] & (gsrc_val | rack_r));

   ////////////////////////////////////////////////////////////////////////
   // Flash phase shared by all lamps so they blink together
   // Half period is FLASH_CYC cycles; the
   // bench shortens it, hardware keeps it
   // Flash colours are lit while phase is high
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         flash_cnt_r <= 25'h0;
         flash_r <= 1'b0;
      end else if (flash_cnt_r == 25'(FLASH_CYC - 1)) begin
         flash_cnt_r <= 25'h0;
         flash_r <= ~flash_r;
      end else begin
         flash_cnt_r <= flash_cnt_r + 25'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lamps
   for (genvar i = 0; i < NUM_LAMPS; i++) begin : g_lamp
      // Each cell sees its own two words and
      // the shared acknowledge, flash and
      // signal set
      lamp_cell u_cell (
         .ref_clk_i(ref_clk_i),
         .sys_rst_i(sys_rst_i),
         .retain_clr_i(pwr_on_clr_i),
         .sig_i(sig_i),
         .slot_sel_i(trig_r[i][SLOTS*SEL_W-1:0]),
         .slot_neg_i(cfg_r[i][CFG_NEG_LSB +: SLOTS]),
         .mode_i(cfg_r[i][CFG_MODE_LSB +: 2]),
         .on_colour_select_i(cfg_r[i][CFG_ON_LSB +: COL_W]),
         .off_colour_select_i(cfg_r[i][CFG_OFF_LSB +: COL_W]),
         .clr_sel_i(cfg_r[i][CFG_CLR_LSB +: SEL_W]),
         .group_ack_i(group_ack),
         .alarm_ack_i(prot_alarm_i),
         .flash_i(flash_r),
         .red_o(lamp_red_o[i]),
         .green_o(lamp_green_o[i]),
         .active_o(active[i]),
         .latched_o(latched[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Health lamp: fixed, flashing while booting, steady once protecting
   // No setting reaches this lamp; it shows
   // boot and protection state only,
   // never a latch
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         health_green_o <= 1'b0;
      end else if (!boot_done_i) begin
         health_green_o <= flash_r;
      end else begin
         health_green_o <= prot_active_i;
      end
   end

endmodule

// [include/lamp_pkg.sv]
package lamp_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int NUM_LAMPS = 8;   // Configurable lamps
   localparam int SIG_W = 32;      // Internal signal set
   localparam int SLOTS = 5;       // Trigger slots per lamp
   localparam int SEL_W = 6;       // Slot select, 0 = unassigned
   localparam int COL_W = 3;       // Colour select width
   localparam int ADDR_W = 8;      // Byte address width

   ////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses)
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] LAMP_BASE = 8'h40;
   localparam logic [7:0] LAMP_STRIDE = 8'h10;
   localparam logic [3:0] TRIG_WORD = 4'h0;  // Slot selects
   localparam logic [3:0] CFG_WORD = 4'h4;   // Negate, mode, colours

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTRL_PERMIT_BIT = 0;  // Remote clear permit
   localparam int CTRL_GSRC_LSB = 1;    // Global clear source select
   localparam int CTRL_RACK_BIT = 8;    // Remote ack, write one
   localparam int CFG_NEG_LSB = 0;
   localparam int CFG_MODE_LSB = 5;
   localparam int CFG_ON_LSB = 7;
   localparam int CFG_OFF_LSB = 10;
   localparam int CFG_CLR_LSB = 13;
   localparam int STAT_LATCH_LSB = 8;
   localparam int STAT_BOOT_BIT = 16;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] TRIG_RST = 32'h0000_0000;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_HZ = 125_000_000;
   localparam int FLASH_HALF_MS = 250;  // Flash half period
   localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;

   ////////////////////////////////////////////////////////////////////////
   // Enumerations
   typedef enum logic [2:0] {
      COL_NONE = 3'h0,
      COL_GREEN = 3'h1,
      COL_RED = 3'h2,
      COL_RED_FLASH = 3'h3,
      COL_GREEN_FLASH = 3'h4
   } colour_t;

   typedef enum logic [1:0] {
      LATCH_OFF = 2'h0,
      LATCH_ON = 2'h1,
      CLEAR_ON_ALARM_LATCH_MODE = 2'h2
   } latch_mode_t;

endpackage

// [testbench/lamp_panel_sva.sv]
`timescale 1ns/100ps
module lamp_panel_chk #(
   parameter int unsigned FLASH_CYC = 4
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Bus
   input wire logic [lamp_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // Health and lamps
   input wire logic boot_done_i,
   input wire logic prot_active_i,
   input wire logic [lamp_pkg::NUM_LAMPS-1:0] lamp_red_o,
   input wire logic [lamp_pkg::NUM_LAMPS-1:0] lamp_green_o,
   input wire logic health_green_o
);
   import lamp_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic health_r; // Last health level
   int hold_r; // Cycles without a health toggle
   ////////////////////////////////////////////////////////////////////////
   // Run length of unchanged health while booting
   always_ff @(posedge ref_clk_i) begin
      health_r <= health_green_o;
      if (sys_rst_i || boot_done_i || health_green_o != health_r) begin
         hold_r <= 0;
      end else begin
         hold_r <= hold_r + 1;
      end
   end
   a_health_flash: assert property (hold_r <= FLASH_CYC + 1)
      else $error("health lamp not flashing");
   a_health_steady: assert property ($past(boot_done_i)
      && !$past(sys_rst_i) |-> health_green_o == $past(prot_active_i))
      else $error("health lamp wrong after boot");
   a_status_boot: assert property (avs_read_i && !avs_waitrequest_o
      && avs_address_i == STAT_OFS
      |-> avs_readdata_o[STAT_BOOT_BIT] == $past(boot_done_i))
      else $error("boot flag wrong");
   a_one_colour: assert property ((lamp_red_o & lamp_green_o) == '0)
      else $error("lamp lit red and green");
   a_reset_dark: assert property ($past(sys_rst_i) |->
      lamp_red_o == '0 && lamp_green_o == '0 && !health_green_o)
      else $error("lamps lit out of reset");
   a_wait_one: assert property ((avs_read_i || avs_write_i)
      && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("wait state count wrong");
   a_idle_nowait: assert property (!(avs_read_i || avs_write_i)
      |-> !avs_waitrequest_o) else $error("wait while idle");
   a_hole_zero: assert property (avs_read_i && !avs_waitrequest_o
      && avs_address_i[3] |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_ctrl_rsvd: assert property (avs_read_i && !avs_waitrequest_o
      && avs_address_i == CTRL_OFS |-> avs_readdata_o[31:7] == '0)
      else $error("control readback bits set");
endmodule
bind lamp_panel lamp_panel_chk #(.FLASH_CYC(FLASH_CYC)) chk_u (
   .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .boot_done_i(boot_done_i),
   .prot_active_i(prot_active_i), .lamp_red_o(lamp_red_o),
   .lamp_green_o(lamp_green_o), .health_green_o(health_green_o));

// [testbench/prot_model.sv]
`timescale 1ns/100ps
module prot_model (
   // Clock
   input wire logic clk_i,
   // Protection side signals
   output logic [31:0] sig_o,
   output logic alarm_o,
   output logic key_o,
   output logic boot_o,
   output logic act_o
);
   // Signal 2 starts high so its negated slot stays quiet
   initial begin
      sig_o = 32'h0000_0004;
      alarm_o = 1'b0;
      key_o = 1'b0;
      boot_o = 1'b0;
      act_o = 1'b0;
   end
   // One signal bit, changed right after an edge
   task put(input int n, input logic v);
      @(posedge clk_i);
      sig_o[n] <= v;
   endtask
   // Key held well past the two-flop sampler
   task press;
      @(posedge clk_i);
      key_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      key_o <= 1'b0;
   endtask
   // Short protection alarm
   task alarm;
      @(posedge clk_i);
      alarm_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      alarm_o <= 1'b0;
   endtask
   // Boot and protection state
   task health(input logic b, input logic a);
      @(posedge clk_i);
      boot_o <= b;
      act_o <= a;
   endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   import lamp_pkg::*;
   localparam logic [7:0] TRG = LAMP_BASE; // Lamp 0 slot selects
   localparam logic [7:0] CFA = LAMP_BASE + 8'h04; // Lamp 0 config
   localparam logic [31:0] T1 = 32'h0000_3001; // Slot1=sig0, slot3=sig2
   logic clk, rst, por, rd, wr, wq, alarm, key, boot, act, hg;
   logic [7:0] addr, red, grn;
   logic [31:0] wdat, rdat, q, sig;
   int fail_count, samples_checked;
   lamp_panel #(.FLASH_CYC(4)) dut_u (.ref_clk_i(clk), .sys_rst_i(rst),
      .pwr_on_clr_i(por), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .sig_i(sig),
      .prot_alarm_i(alarm), .boot_done_i(boot), .prot_active_i(act),
      .clear_key_i(key), .lamp_red_o(red), .lamp_green_o(grn),
      .health_green_o(hg));
   prot_model far_u (.clk_i(clk), .sig_o(sig), .alarm_o(alarm),
      .key_o(key), .boot_o(boot), .act_o(act));
   ////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Compare and count
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One bus cycle; held until waitrequest is seen low at an edge
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
      end while (wq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Config word for lamp 0
   function logic [31:0] cfg(int md, int on, int off, int clr);
      return 32'((6 << CFG_NEG_LSB) | (md << CFG_MODE_LSB) |
         (on << CFG_ON_LSB) | (off << CFG_OFF_LSB) | (clr << CFG_CLR_LSB));
   endfunction
   // All lamps after they settle; only lamp 0 is ever lit
   task lamp(input logic [1:0] e);
      repeat (6) @(negedge clk);
      chk({16'h0, red, grn}, {23'h0, e[1], 7'h0, e[0]});
   endtask
   // One-cycle trigger pulse on signal 0
   task latch;
      far_u.put(0, 1'b1);
      far_u.put(0, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Reset values, mid-run reset and unmapped places
   task t_regs;
      bus(0, CFA, 0);
      chk(q, CFG_RST);
      bus(1, CFA, cfg(1, 2, 1, 0));
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(0, CFA, 0);
      chk(q, cfg(1, 2, 1, 0));
      bus(1, 8'h48, 32'hFFFF_FFFF);
      bus(0, 8'h48, 0);
      chk(q, 32'h0);
   endtask
   // Unlatched lamp follows its slots
   task t_follow;
      bus(1, TRG, T1);
      bus(1, CFA, cfg(0, 2, 1, 0));
      lamp(2'b01);
      far_u.put(0, 1'b1);
      lamp(2'b10);
      far_u.put(0, 1'b0);
      lamp(2'b01);
      far_u.put(2, 1'b0);
      lamp(2'b10);
      far_u.put(2, 1'b1);
   endtask
   // Every colour code, active and idle: {seen lit, always lit}
   task t_colours;
      logic [1:0] o, a;
      logic [3:0] ex [5];
      ex = '{4'b0000, 4'b0101, 4'b1010, 4'b1000, 4'b0100};
      for (int c = 0; c < 5; c++) begin
         bus(1, CFA, cfg(0, c, 4 - c, 0));
         for (int t = 1; t >= 0; t--) begin
            far_u.put(0, t[0]);
            repeat (3) @(negedge clk);
            o = 2'b00;
            a = 2'b11;
            repeat (12) begin
               @(negedge clk);
               o = o | {red[0], grn[0]};
               a = a & {red[0], grn[0]};
            end
            chk({28'h0, o, a}, {28'h0, ex[t ? c : 4 - c]});
         end
      end
   endtask
   // Latch, own clear, discarded clear, mode and slot release
   task t_latch;
      bus(1, CFA, cfg(1, 2, 1, 5));
      latch;
      lamp(2'b10);
      bus(0, STAT_OFS, 0);
      chk(32'(q[STAT_LATCH_LSB]), 32'h1);
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      lamp(2'b10);
      far_u.put(0, 1'b1);
      far_u.put(4, 1'b1);
      far_u.put(4, 1'b0);
      far_u.put(0, 1'b0);
      lamp(2'b10);
      far_u.put(4, 1'b1);
      far_u.put(4, 1'b0);
      lamp(2'b01);
      latch;
      bus(1, CFA, cfg(0, 2, 1, 5));
      lamp(2'b01);
      bus(1, CFA, cfg(1, 2, 1, 5));
      latch;
      bus(1, TRG, 32'h0);
      lamp(2'b01);
      bus(1, TRG, T1);
   endtask
   // Global source and remote ack, with and without permit
   task t_global;
      bus(1, CFA, cfg(1, 2, 1, 0));
      latch;
      bus(1, CTRL_OFS, 32'h0000_000C);
      far_u.put(5, 1'b1);
      far_u.put(5, 1'b0);
      lamp(2'b10);
      bus(1, CTRL_OFS, 32'h0000_010C);
      lamp(2'b10);
      bus(1, CTRL_OFS, 32'h0000_000D);
      bus(0, CTRL_OFS, 0);
      chk(q, 32'h0000_000D);
      far_u.put(5, 1'b1);
      far_u.put(5, 1'b0);
      lamp(2'b01);
      latch;
      bus(1, CTRL_OFS, 32'h0000_010D);
      lamp(2'b01);
      bus(1, CTRL_OFS, 32'h0);
   endtask
   // Panel key and protection alarm
   task t_key_alarm;
      latch;
      far_u.press;
      lamp(2'b01);
      bus(1, CFA, cfg(2, 2, 1, 0));
      latch;
      far_u.alarm;
      lamp(2'b01);
      bus(1, CFA, cfg(1, 2, 1, 0));
      latch;
      far_u.alarm;
      lamp(2'b10);
   endtask
   // Health lamp after boot
   task t_health;
      far_u.health(1'b1, 1'b1);
      repeat (3) @(negedge clk);
      chk(32'(hg), 32'h1);
      bus(0, STAT_OFS, 0);
      chk(32'(q[STAT_BOOT_BIT]), 32'h1);
      far_u.health(1'b1, 1'b0);
      repeat (3) @(negedge clk);
      chk(32'(hg), 32'h0);
   endtask
   // Verdict and end of run
   task summarize;
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      fail_count = 0;
      samples_checked = 0;
      rst = 1'b1;
      por = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = 8'h00;
      wdat = 32'h0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      t_regs;
      t_follow;
      t_colours;
      t_latch;
      t_global;
      t_key_alarm;
      t_health;
      summarize;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      summarize;
   end
endmodule
